// ==== rtl/tcc_pkg.sv ====
// constants, encodings and carrier types of the 8-bit timer/counter with two compare channels
package tcc_pkg;

    localparam int unsigned ADDR_W       = 4;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned PRE_W_DEF    = 10;

    // register offsets
    localparam logic [3:0]  OFS_CTRL_A   = 4'h0;
    localparam logic [3:0]  OFS_CTRL_B   = 4'h1;
    localparam logic [3:0]  OFS_COUNT    = 4'h2;
    localparam logic [3:0]  OFS_CMP_A    = 4'h3;
    localparam logic [3:0]  OFS_CMP_B    = 4'h4;
    localparam logic [3:0]  OFS_FLAG     = 4'h5;
    localparam logic [3:0]  OFS_MASK     = 4'h6;
    localparam logic [3:0]  OFS_ASYNC    = 4'h7;
    localparam logic [3:0]  OFS_PORT     = 4'h8;

    // control register a fields
    localparam int unsigned CA_COM_A_LSB = 6;
    localparam int unsigned CA_COM_B_LSB = 4;
    localparam int unsigned CA_WGM_LSB   = 0;
    // control register b fields
    localparam int unsigned CB_FOC_A     = 7;
    localparam int unsigned CB_FOC_B     = 6;
    localparam int unsigned CB_WGM2      = 3;
    localparam int unsigned CB_CS_LSB    = 0;
    // flag and mask fields
    localparam int unsigned FL_OVF       = 0;
    localparam int unsigned FL_CMP_A     = 1;
    localparam int unsigned FL_CMP_B     = 2;
    // async status field
    localparam int unsigned AS_SEL       = 3;
    // port register fields: data in bits 1:0, direction in bits 5:4
    localparam int unsigned PT_DATA_LSB  = 0;
    localparam int unsigned PT_DIR_LSB   = 4;

    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [7:0]  CNT_BOTTOM   = 8'h00;
    localparam logic [7:0]  CNT_MAX      = 8'hFF;

    // prescaler tap bit for clock select codes 2 to 7 (divide 8, 32, 64, 128, 256, 1024)
    localparam int unsigned TAP_CS2      = 3;
    localparam int unsigned TAP_CS3      = 5;
    localparam int unsigned TAP_CS4      = 6;
    localparam int unsigned TAP_CS5      = 7;
    localparam int unsigned TAP_CS6      = 8;
    localparam int unsigned TAP_CS7      = 10;

    typedef enum logic [2:0] {
        WGM_NORMAL   = 3'b000,
        WGM_PC_MAX   = 3'b001,
        WGM_CTC      = 3'b010,
        WGM_FAST_MAX = 3'b011,
        WGM_RSV4     = 3'b100,
        WGM_PC_CMP   = 3'b101,
        WGM_RSV6     = 3'b110,
        WGM_FAST_CMP = 3'b111
    } tcc_wgm_t;

    typedef enum logic [1:0] {
        COM_OFF    = 2'b00,
        COM_TOGGLE = 2'b01,
        COM_CLEAR  = 2'b10,
        COM_SET    = 2'b11
    } tcc_com_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } tcc_req_t;

    typedef struct packed {
        logic out;
        logic oe;
    } tcc_pin_t;

endpackage

// ==== rtl/tcc_timer.sv ====
// 8-bit timer/counter core with two compare channels, waveform pin override and register port
//
// Function
// - counter and both compare values are eight-bit registers.
// - every interrupt request has a flag and its own mask bit.
// - timer clock is the system clock unless async select picks the crystal.
// - clock select zero keeps the counter stopped.
// - each timer clock clears, increments or decrements by one, per mode.
// - cpu reads and writes counter anytime; its write beats count or clear.
// - bottom is 0x00, max 0xFF; top is max or compare a.
// - top and bottom indicators steer the waveform extreme cases.
// - three-bit waveform mode: two low bits in ctrl a, high bit in ctrl b.
// - comparators run always; match sets the flag on the next timer clock.
// - compare flag clears on service or by writing one.
// - pwm modes buffer compare values, loaded at top or bottom only.
// - cpu reaches the buffer when buffering, else the active compare value.
// - force strobe in non-pwm modes acts on the output, no flag, no clear.
// - counter write blocks matches in the next timer clock, even stopped.
// - waveform output register keeps its value across mode changes.
// - compare output mode bits act at once, unbuffered.
// - nonzero output mode puts the waveform on the pin; direction stays.
// - overflow flag sets at the mode's point and can interrupt.
// - output mode bits choose match action and pin ownership.
// - mode 0 counts up, wraps, overflow flag sets as count becomes zero.
// - mode 2 clears counter on compare a match.
// - modes 3 and 7 are fast pwm, top max or compare a.
// - output mode zero leaves the waveform register alone at matches.
`timescale 1ns/1ps
module tcc_timer
    import tcc_pkg::*;
#(
    parameter int unsigned PRE_W = tcc_pkg::PRE_W_DEF
) (
    input  wire logic                       mclk,
    input  wire logic                       rstn,
    input  wire logic                       ce,
    input  wire tcc_pkg::tcc_req_t          req,
    output      logic [tcc_pkg::DATA_W-1:0] rdata,
    input  wire logic [2:0]                 irq_ack,
    output      logic [2:0]                 irq_req,
    input  wire logic                       crystal_pin_in,
    output      logic                       crystal_pin_out,
    output      tcc_pkg::tcc_pin_t [1:0]    wave_pin
);
    import tcc_pkg::*;

    if (PRE_W < TAP_CS7) begin : g_chk
        $error("prescaler too narrow for the slowest tap");
    end

    // the read mux and the shadow layout assume eight-bit registers
    if (DATA_W != 8) begin : g_chk_data
        $error("register width must be eight bits");
    end

    // nine registers need at least four address bits
    if (ADDR_W < 4) begin : g_chk_addr
        $error("address too narrow for the register map");
    end

    // register state
    logic [1:0]       com_q [2];
    logic [1:0]       com_d [2];
    logic [7:0]       cmp_q [2];
    logic [7:0]       cmp_d [2];
    logic [7:0]       buf_q [2];
    logic [7:0]       buf_d [2];
    logic [1:0]       oc_q, oc_d;
    logic [2:0]       wgm_q, wgm_d;
    logic [2:0]       cs_q, cs_d;
    logic [7:0]       cnt_q, cnt_d;
    logic             down_q, down_d;
    logic             blk_q, blk_d;
    logic [2:0]       flag_q, flag_d;
    logic [2:0]       mask_q, mask_d;
    logic             as_q, as_d;
    logic [1:0]       pdat_q, pdat_d;
    logic [1:0]       pdir_q, pdir_d;
    logic [PRE_W-1:0] pre_q, pre_d;
    logic             xs1_q, xs2_q, xs3_q;
    logic             xout_d, xout_q;
    logic [7:0]       rdata_d, rdata_q;
    logic [2:0]       irq_d, irq_q;
    tcc_pin_t [1:0]   pin_d, pin_q;

    // decode
    logic             src_tick, tick, pwm, pc, at_top, at_bot;
    logic             hit_ca, hit_cb, hit_cnt, hit_flag;
    logic [7:0]       top_val;
    logic [1:0]       match, fire;
    logic [2:0]       fset, fclr;
    tcc_wgm_t         mode;

    function automatic logic hit(input tcc_req_t r, input logic [3:0] ofs);
        return r.wr && (r.addr == ofs);
    endfunction

    function automatic logic tap(input logic [2:0] cs, input logic [PRE_W-1:0] p);
        unique case (cs)
            3'd1:    tap = 1'b1;
            3'd2:    tap = &p[TAP_CS2-1:0];
            3'd3:    tap = &p[TAP_CS3-1:0];
            3'd4:    tap = &p[TAP_CS4-1:0];
            3'd5:    tap = &p[TAP_CS5-1:0];
            3'd6:    tap = &p[TAP_CS6-1:0];
            3'd7:    tap = &p[TAP_CS7-1:0];
            default: tap = 1'b0;
        endcase
    endfunction

    always_comb begin
        mode     = tcc_wgm_t'(wgm_q);
        pwm      = wgm_q[0];
        pc       = (mode == WGM_PC_MAX) || (mode == WGM_PC_CMP);
        top_val  = (mode == WGM_CTC || mode == WGM_PC_CMP || mode == WGM_FAST_CMP) ? cmp_q[0] : CNT_MAX;
        at_top   = (cnt_q == top_val);
        at_bot   = (cnt_q == CNT_BOTTOM);
        // only the second stage follows the first, so no other logic sees the first stage
        src_tick = as_q ? (xs2_q & ~xs3_q) : 1'b1;
        tick     = src_tick && tap(cs_q, pre_q);
        hit_ca   = hit(req, OFS_CTRL_A);
        hit_cb   = hit(req, OFS_CTRL_B);
        hit_cnt  = hit(req, OFS_COUNT);
        hit_flag = hit(req, OFS_FLAG);
        for (int i = 0; i < 2; i++) begin
            match[i] = (cnt_q == cmp_q[i]) && !blk_q;
            fire[i]  = match[i] && tick;
        end

        com_d  = com_q;
        cmp_d  = cmp_q;
        buf_d  = buf_q;
        oc_d   = oc_q;
        wgm_d  = wgm_q;
        cs_d   = cs_q;
        cnt_d  = cnt_q;
        down_d = down_q;
        blk_d  = blk_q;
        mask_d = mask_q;
        as_d   = as_q;
        pdat_d = pdat_q;
        pdir_d = pdir_q;
        pre_d  = src_tick ? pre_q + 1'b1 : pre_q;
        fset   = 3'b000;

        // counter sequence
        if (tick) begin
            blk_d = 1'b0;
            if (pc) begin
                if (!down_q && at_top) begin
                    down_d = 1'b1;
                    cnt_d  = cnt_q - 1'b1;
                end else if (down_q && at_bot) begin
                    down_d     = 1'b0;
                    cnt_d      = cnt_q + 1'b1;
                    fset[FL_OVF] = 1'b1;
                end else begin
                    cnt_d = down_q ? cnt_q - 1'b1 : cnt_q + 1'b1;
                end
            end else begin
                down_d = 1'b0;
                if (at_top) begin
                    cnt_d = CNT_BOTTOM;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
                // ctc overflows only on the pass from max, other single-slope modes at top
                if (mode == WGM_CTC ? cnt_q == CNT_MAX : at_top) begin
                    fset[FL_OVF] = 1'b1;
                end
            end
            fset[FL_CMP_A] = match[0];
            fset[FL_CMP_B] = match[1];
            // double buffer load: fast pwm at bottom, phase correct at top
            if (pwm && at_top && (pc ? !down_q : 1'b1)) begin
                cmp_d = buf_q;
            end
        end
        if (hit_cnt) begin
            cnt_d = req.wdata;
            blk_d = 1'b1;
        end

        // waveform registers
        for (int i = 0; i < 2; i++) begin
            unique case (tcc_com_t'(com_q[i]))
                COM_TOGGLE: begin
                    if (fire[i] && (!pwm || (i == 0 && mode == WGM_FAST_CMP))) begin
                        oc_d[i] = ~oc_q[i];
                    end
                end
                COM_CLEAR, COM_SET: begin
                    if (fire[i]) begin
                        oc_d[i] = (pwm && pc && down_q) ? !com_q[i][0] : com_q[i][0];
                    end
                    if (pwm && !pc && tick && at_top) begin
                        oc_d[i] = !com_q[i][0];
                    end
                end
                COM_OFF: ;
            endcase
        end
        if (hit_cb && !pwm) begin
            for (int i = 0; i < 2; i++) begin
                if (req.wdata[CB_FOC_A - i]) begin
                    unique case (tcc_com_t'(com_q[i]))
                        COM_TOGGLE: oc_d[i] = ~oc_q[i];
                        COM_CLEAR:  oc_d[i] = 1'b0;
                        COM_SET:    oc_d[i] = 1'b1;
                        COM_OFF:    ;
                    endcase
                end
            end
        end

        // register writes
        if (hit_ca) begin
            com_d[0]   = req.wdata[CA_COM_A_LSB +: 2];
            com_d[1]   = req.wdata[CA_COM_B_LSB +: 2];
            wgm_d[1:0] = req.wdata[CA_WGM_LSB +: 2];
        end
        if (hit_cb) begin
            wgm_d[2] = req.wdata[CB_WGM2];
            cs_d     = req.wdata[CB_CS_LSB +: 3];
        end
        for (int i = 0; i < 2; i++) begin
            if (hit(req, i == 0 ? OFS_CMP_A : OFS_CMP_B)) begin
                buf_d[i] = req.wdata;
                if (!pwm) begin
                    cmp_d[i] = req.wdata;
                end
            end
        end
        if (hit(req, OFS_MASK)) begin
            mask_d = req.wdata[2:0];
        end
        if (hit(req, OFS_ASYNC)) begin
            as_d = req.wdata[AS_SEL];
        end
        if (hit(req, OFS_PORT)) begin
            pdat_d = req.wdata[PT_DATA_LSB +: 2];
            pdir_d = req.wdata[PT_DIR_LSB +: 2];
        end

        // flags: hardware set wins over a clear in the same cycle
        fclr   = irq_ack | (hit_flag ? req.wdata[2:0] : 3'b000);
        flag_d = (flag_q & ~fclr) | fset;
        irq_d  = flag_q & mask_q;

        // pin override: direction always from the port direction bit
        for (int i = 0; i < 2; i++) begin
            pin_d[i].out = (com_q[i] != COM_OFF) ? oc_q[i] : pdat_q[i];
            pin_d[i].oe  = pdir_q[i];
        end
        xout_d = as_q & ~xs2_q;

        // read data stands only in the cycle after the strobe
        rdata_d = 8'h00;
        if (req.rd) begin
            unique case (req.addr)
                OFS_CTRL_A: rdata_d = {com_q[0], com_q[1], 2'b00, wgm_q[1:0]};
                OFS_CTRL_B: rdata_d = {4'h0, wgm_q[2], cs_q};
                OFS_COUNT:  rdata_d = cnt_q;
                OFS_CMP_A:  rdata_d = pwm ? buf_q[0] : cmp_q[0];
                OFS_CMP_B:  rdata_d = pwm ? buf_q[1] : cmp_q[1];
                OFS_FLAG:   rdata_d = {5'h00, flag_q};
                OFS_MASK:   rdata_d = {5'h00, mask_q};
                OFS_ASYNC:  rdata_d = {4'h0, as_q, 3'b000};
                OFS_PORT:   rdata_d = {2'b00, pdir_q, 2'b00, pdat_q};
                default:    rdata_d = 8'h00;
            endcase
        end
    end

    // software-visible control state
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            com_q   <= '{2'b00, 2'b00};
            cmp_q   <= '{RST_BYTE, RST_BYTE};
            buf_q   <= '{RST_BYTE, RST_BYTE};
            wgm_q   <= 3'b000;
            cs_q    <= 3'b000;
            mask_q  <= 3'b000;
            as_q    <= 1'b0;
            pdat_q  <= 2'b00;
            pdir_q  <= 2'b00;
        end else if (ce) begin
            com_q   <= com_d;
            cmp_q   <= cmp_d;
            buf_q   <= buf_d;
            wgm_q   <= wgm_d;
            cs_q    <= cs_d;
            mask_q  <= mask_d;
            as_q    <= as_d;
            pdat_q  <= pdat_d;
            pdir_q  <= pdir_d;
        end
    end

    // counting state, flags and waveform registers
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            oc_q    <= 2'b00;
            cnt_q   <= RST_BYTE;
            down_q  <= 1'b0;
            blk_q   <= 1'b0;
            flag_q  <= 3'b000;
            pre_q   <= '0;
        end else if (ce) begin
            oc_q    <= oc_d;
            cnt_q   <= cnt_d;
            down_q  <= down_d;
            blk_q   <= blk_d;
            flag_q  <= flag_d;
            pre_q   <= pre_d;
        end
    end

    // crystal synchroniser: a frozen clock enable also freezes it, so a crystal pulse that falls wholly inside the freeze is lost
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            xs1_q   <= 1'b0;
            xs2_q   <= 1'b0;
            xs3_q   <= 1'b0;
        end else if (ce) begin
            xs1_q   <= crystal_pin_in;
            xs2_q   <= xs1_q;
            xs3_q   <= xs2_q;
        end
    end

    // output registers, so every port comes straight from a flip-flop
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            xout_q  <= 1'b0;
            rdata_q <= RST_BYTE;
            irq_q   <= 3'b000;
            pin_q   <= '0;
        end else if (ce) begin
            xout_q  <= xout_d;
            rdata_q <= rdata_d;
            irq_q   <= irq_d;
            pin_q   <= pin_d;
        end
    end

    assign rdata           = rdata_q;
    assign irq_req         = irq_q;
    assign crystal_pin_out = xout_q;
    assign wave_pin        = pin_q;

endmodule

// ==== verif/tcc_checker.sv ====
// checker: register readback, pin ownership and interrupt gating at the timer ports
`timescale 1ns/1ps
module tcc_checker
    import tcc_pkg::*;
(
    input wire logic                       mclk,
    input wire logic                       rstn,
    input wire logic                       ce,
    input wire tcc_pkg::tcc_req_t          req,
    input wire logic [tcc_pkg::DATA_W-1:0] rdata,
    input wire logic [2:0]                 irq_ack,
    input wire logic [2:0]                 irq_req,
    input wire logic                       crystal_pin_in,
    input wire logic                       crystal_pin_out,
    input wire tcc_pkg::tcc_pin_t [1:0]    wave_pin
);
    logic [7:0] ca_q, ca_d, mk_q, mk_d, as_q, as_d, pt_q, pt_d;

    function automatic logic [7:0] upd(logic [7:0] q, tcc_req_t r, logic c, logic [3:0] a);
        return (c && r.wr && r.addr == a) ? r.wdata : q;
    endfunction

    // shadows rebuilt from bus traffic, so the checks need nothing inside the block
    always_comb begin
        ca_d = upd(ca_q, req, ce, OFS_CTRL_A);
        mk_d = upd(mk_q, req, ce, OFS_MASK);
        as_d = upd(as_q, req, ce, OFS_ASYNC);
        pt_d = upd(pt_q, req, ce, OFS_PORT);
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ca_q <= RST_BYTE;
            mk_q <= RST_BYTE;
            as_q <= RST_BYTE;
            pt_q <= RST_BYTE;
        end else begin
            ca_q <= ca_d;
            mk_q <= mk_d;
            as_q <= as_d;
            pt_q <= pt_d;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence s_rd(logic [3:0] a);
        req.rd && req.addr == a;
    endsequence

    a_rdata_idle: assert property (!$past(req.rd) |-> rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    a_unmapped_read: assert property (req.rd && req.addr > OFS_PORT |=> rdata == 8'h00)
        else $error("unmapped read returned data");
    a_ctrl_readback: assert property (s_rd(OFS_CTRL_A) |=> (rdata & 8'hF3) == ($past(ca_q) & 8'hF3))
        else $error("control a readback differs");
    a_force_reads0: assert property (s_rd(OFS_CTRL_B) |=> rdata[7:6] == 2'b00)
        else $error("force strobe bits read back set");
    a_mask_readback: assert property (s_rd(OFS_MASK) |=> rdata[2:0] == $past(mk_q[2:0]))
        else $error("mask readback differs");
    a_async_readback: assert property (s_rd(OFS_ASYNC) |=> rdata[AS_SEL] == $past(as_q[AS_SEL]))
        else $error("async select readback differs");
    a_irq_masked: assert property ((irq_req & ~$past(mk_q[2:0])) == 3'b000)
        else $error("interrupt request with mask bit clear");
    a_dir_to_pin: assert property (wave_pin[0].oe == $past(pt_q[PT_DIR_LSB]) &&
        wave_pin[1].oe == $past(pt_q[PT_DIR_LSB+1]))
        else $error("pin enable does not follow direction bit");
    a_port_owns_a: assert property ($past(ca_q[7:6]) == 2'b00 |-> wave_pin[0].out == $past(pt_q[0]))
        else $error("pin a not driven from port data");
    a_port_owns_b: assert property ($past(ca_q[5:4]) == 2'b00 |-> wave_pin[1].out == $past(pt_q[1]))
        else $error("pin b not driven from port data");
    a_xtal_idle: assert property (!$past(as_q[AS_SEL]) |-> crystal_pin_out == 1'b0)
        else $error("crystal output active while async off");
endmodule

bind tcc_timer tcc_checker u_chk (.mclk(mclk), .rstn(rstn), .ce(ce), .req(req), .rdata(rdata),
    .irq_ack(irq_ack), .irq_req(irq_req), .crystal_pin_in(crystal_pin_in),
    .crystal_pin_out(crystal_pin_out), .wave_pin(wave_pin));

// ==== verif/tcc_timer_tb_top.sv ====
// self-checking bench: register model, counting, flags, force strobe and pin override
`timescale 1ns/1ps
module tcc_timer_tb_top;
    import tcc_pkg::*;
    localparam logic [3:0] RA [0:3] = '{OFS_COUNT, OFS_CMP_A, OFS_CMP_B, OFS_MASK};
    localparam logic [1:0] CM [0:4] = '{2'd3, 2'd2, 2'd1, 2'd1, 2'd0};
    logic           mclk, rstn, ce, xin, xout, oc;
    tcc_req_t       req;
    logic [7:0]     rdata, q, v;
    logic [2:0]     ack, irq;
    tcc_pin_t [1:0] pin;
    logic [7:0]     m [0:15];
    int             n_fail, checks, seed, k;

    tcc_timer #(.PRE_W(10)) dut (.mclk(mclk), .rstn(rstn), .ce(ce), .req(req), .rdata(rdata),
        .irq_ack(ack), .irq_req(irq), .crystal_pin_in(xin), .crystal_pin_out(xout), .wave_pin(pin));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic summarize;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // the flag register is modelled by hand, since hardware sets it
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge mclk);
        req.wr <= 1'b0;
        if (a <= OFS_PORT && a != OFS_FLAG)
            m[a] = (a == OFS_CTRL_B) ? (d & 8'h3F) : d;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge mclk);
        req.rd <= 1'b0;
        #1 q = rdata;
    endtask

    task automatic rchk(input logic [3:0] a);
        rd(a);
        chk($sformatf("reg_%0h", a), m[a], q);
    endtask

    task automatic wflag(input int b, input int lim);
        for (int j = 0; j < lim; j++) begin
            rd(OFS_FLAG);
            if (q[b] === 1'b1)
                return;
        end
        chk("flag_wait", 8'h01, 8'h00);
        summarize();
    endtask

    // pin out and enable one cycle after the strobe edge
    task automatic pchk(input logic ea, input logic eb);
        @(posedge mclk);
        #1;
        chk("pin_a", {6'h0, v[4], ea}, {6'h0, pin[0].oe, pin[0].out});
        chk("pin_b", {6'h0, v[5], eb}, {6'h0, pin[1].oe, pin[1].out});
    endtask

    initial begin
        repeat (100000) @(posedge mclk);
        chk("watchdog", 8'h00, 8'h01);
        summarize();
    end

    initial begin
        seed = 92;
        n_fail = 0;
        checks = 0;
        rstn = 1'b0;
        ce = 1'b1;
        xin = 1'b0;
        ack = 3'b000;
        req = '0;
        oc = 1'b0;
        v = 8'h00;
        for (k = 0; k < 16; k++) m[k] = 8'h00;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        for (k = 0; k < 16; k++) rchk(4'(k));
        for (k = 0; k < 12; k++) begin
            v = 8'($random(seed));
            if (k % 4 == 3) v = v & 8'h07;
            wr(RA[k % 4], v);
            repeat (k) @(posedge mclk);
            rchk(RA[k % 4]);
        end
        wr(4'hC, v);
        rchk(4'hC);
        // counter loaded equal to compare a: that first match is lost
        wr(OFS_CMP_A, 8'h40);
        wr(OFS_CMP_B, 8'h42);
        wr(OFS_COUNT, 8'h40);
        wr(OFS_CTRL_B, 8'h01);
        wflag(FL_CMP_B, 10);
        m[OFS_FLAG] = 8'h04;
        rchk(OFS_FLAG);
        wr(OFS_FLAG, 8'h04);
        m[OFS_FLAG] = 8'h00;
        rchk(OFS_FLAG);
        wr(OFS_MASK, 8'h01);
        wflag(FL_OVF, 200);
        rd(OFS_COUNT);
        chk("wrap", 8'h01, {7'h0, q < 8'h10});
        chk("irq", 8'h01, {7'h0, irq[0]});
        @(posedge mclk);
        ack <= 3'b001;
        @(posedge mclk);
        ack <= 3'b000;
        rd(OFS_FLAG);
        chk("ovf_ack", 8'h00, {7'h0, q[FL_OVF]});
        wr(OFS_CMP_A, 8'h10);
        wr(OFS_CTRL_A, 8'h02);
        repeat (270) @(posedge mclk);
        wr(OFS_FLAG, 8'h07);
        for (k = 0; k < 24; k++) begin
            rd(OFS_COUNT);
            chk("ctc", 8'h01, {7'h0, q <= 8'h10});
        end
        rd(OFS_FLAG);
        chk("ctc_flags", 8'h02, q);
        wr(OFS_CTRL_B, 8'h00);
        wr(OFS_FLAG, 8'h07);
        v = 8'($random(seed)) & 8'h33;
        wr(OFS_PORT, v);
        for (k = 0; k < 5; k++) begin
            wr(OFS_CTRL_A, {CM[k], CM[k], 4'h0});
            wr(OFS_CTRL_B, 8'hC0);
            oc = (CM[k] == 2'd1) ? ~oc : (CM[k] == 2'd0) ? oc : CM[k][0];
            pchk(CM[k] != 0 ? oc : v[0], CM[k] != 0 ? oc : v[1]);
        end
        rd(OFS_FLAG);
        chk("force_flag", 8'h00, q);
        wr(OFS_CTRL_A, 8'hF3);
        pchk(oc, oc);
        wr(OFS_CTRL_B, 8'hC0);
        pchk(oc, oc);
        // crystal pulses slow enough for the three-stage synchroniser
        wr(OFS_CTRL_A, 8'h00);
        wr(OFS_COUNT, 8'h00);
        wr(OFS_ASYNC, 8'h08);
        wr(OFS_CTRL_B, 8'h01);
        for (k = 0; k < 5; k++) begin
            xin <= 1'b1;
            repeat (8) @(posedge mclk);
            xin <= 1'b0;
            repeat (8) @(posedge mclk);
        end
        m[OFS_COUNT] = 8'h05;
        rchk(OFS_COUNT);
        wr(OFS_CTRL_B, 8'h00);
        wr(OFS_ASYNC, 8'h00);
        for (k = 0; k < 9; k++) rchk(4'(k));
        // fast pwm at max top: compare a write lands in the buffer, active after top
        wr(OFS_CTRL_A, 8'h83);
        wr(OFS_CMP_A, 8'h80);
        rchk(OFS_CMP_A);
        wr(OFS_CTRL_B, 8'h01);
        repeat (300 + 8'($random(seed))) @(posedge mclk);
        wr(OFS_CTRL_B, 8'h00);
        rd(OFS_COUNT);
        pchk(q <= 8'h80, v[1]);
        summarize();
    end
endmodule
